/* File: sim/fdcr_disk_model.sv */
// Disk side model: one write burst then read and write data edges
`timescale 1ns/100ps
module fdcr_disk_model
(
    // Clock and trigger
    input wire logic clk,
    input wire logic go,
    // Disk levels
    output logic wr_gate,
    output logic rdata,
    output logic wdata
);
    logic [5:0] cnt_q = 6'h00;
    always_ff @(posedge clk)
    begin
        if (go)
            cnt_q <= 6'h01;
        else if (cnt_q != 6'h00 && cnt_q != 6'h28)
            cnt_q <= cnt_q + 6'h01;
    end
    assign wr_gate = cnt_q >= 6'h01 && cnt_q <= 6'h0A;
    assign rdata = cnt_q >= 6'h0C && cnt_q <= 6'h0F;
    assign wdata = cnt_q >= 6'h14 && cnt_q <= 6'h17;
endmodule

/* File: sim/fdcr_regs_assertions.sv */
// Checker for the drive control register ports
`timescale 1ns/100ps
module fdcr_regs_checker
import fdcr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Host bus
    input wire logic [9:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic [7:0] IO_RDATA_OE,
    // Configuration
    input wire fdcr_pkg::fdcr_mode_e STATUS_MODE,
    input wire logic SWAP_DECODE,
    input wire logic ENH_FLOPPY_MODE2,
    input wire logic [1:0] BOOT_DRIVE,
    // Outputs watched
    input wire logic DRIVE_SEL_OUT_0_N,
    input wire logic DRIVE_SEL_OUT_1_N,
    input wire logic MOTOR_ON_OUT_0_N,
    input wire logic CTRL_RESET_N,
    input wire logic DRQ_OE,
    input wire logic FLOPPY_IRQ_OE,
    input wire logic DACK_N_GATED,
    input wire logic TC_GATED
);
    // ****
    // Properties
    // ****
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    wire octl_wr = IO_WR && IO_ADDR == FDCR_ADDR_OCTL;
    a_stat_fixed_ones: assert property (
        IO_RD && IO_ADDR == FDCR_ADDR_STATUS_B && STATUS_MODE == FDCR_MODE_ALT
        |=> IO_RDATA_OE == 8'hFF && (IO_RDATA & FDCR_LSTAT_ONES) == FDCR_LSTAT_ONES)
        else $error("fixed status bits wrong");
    a_sel_normal: assert property (
        octl_wr && !SWAP_DECODE && IO_WDATA[1:0] == 2'h0 && IO_WDATA[4]
        |=> !DRIVE_SEL_OUT_0_N && DRIVE_SEL_OUT_1_N && !MOTOR_ON_OUT_0_N)
        else $error("normal decode wrong");
    a_sel_swapped: assert property (
        octl_wr && SWAP_DECODE && IO_WDATA[1:0] == 2'h1 && IO_WDATA[5]
        |=> !DRIVE_SEL_OUT_0_N && DRIVE_SEL_OUT_1_N && !MOTOR_ON_OUT_0_N)
        else $error("swapped decode wrong");
    a_soft_reset_hold: assert property (
        octl_wr && !IO_WDATA[2] |=> !CTRL_RESET_N)
        else $error("soft reset not held");
    a_soft_reset_width: assert property (
        $rose(CTRL_RESET_N) |-> !$past(CTRL_RESET_N, 25))
        else $error("soft reset too short");
    a_tape_normal_oe: assert property (
        IO_RD && IO_ADDR == FDCR_ADDR_TAPE && !ENH_FLOPPY_MODE2
        |=> IO_RDATA_OE == FDCR_TAPE_OE_NORMAL)
        else $error("tape read drives high bits");
    a_tape_boot_field: assert property (
        IO_RD && IO_ADDR == FDCR_ADDR_TAPE && ENH_FLOPPY_MODE2
        |=> IO_RDATA_OE == 8'hFF && IO_RDATA[3:2] == $past(BOOT_DRIVE))
        else $error("boot drive field wrong");
    a_ext_pins_on: assert property (
        STATUS_MODE == FDCR_MODE_EXT |=> DRQ_OE && FLOPPY_IRQ_OE)
        else $error("pins off in extended mode");
    a_gated_inputs_idle: assert property (
        !DRQ_OE |-> DACK_N_GATED && !TC_GATED)
        else $error("inputs not ignored");
    a_motor_hi_zero: assert property (
        IO_RD && IO_ADDR == FDCR_ADDR_OCTL |=> IO_RDATA[7:6] == 2'h0)
        else $error("upper motor bits nonzero");
    c_alt_read: cover property (IO_RD && IO_ADDR == FDCR_ADDR_STATUS_B);
    c_release: cover property ($rose(CTRL_RESET_N));
    c_swap_wr: cover property (octl_wr && SWAP_DECODE);
endmodule

bind fdcr_regs fdcr_regs_checker u_chk (.CLK, .RESET_N, .IO_ADDR, .IO_RD, .IO_WR,
    .IO_WDATA, .IO_RDATA, .IO_RDATA_OE, .STATUS_MODE, .SWAP_DECODE, .ENH_FLOPPY_MODE2,
    .BOOT_DRIVE, .DRIVE_SEL_OUT_0_N, .DRIVE_SEL_OUT_1_N, .MOTOR_ON_OUT_0_N,
    .CTRL_RESET_N, .DRQ_OE, .FLOPPY_IRQ_OE, .DACK_N_GATED, .TC_GATED);

/* File: sim/tb_fdcr_regs.sv */
// Self-checking bench for the drive control registers
`timescale 1ns/100ps
module tb_fdcr_regs;
import fdcr_pkg::*;
    // ****
    // Stimulus and observed nets
    // ****
    logic clk = 0, rst_n = 0, io_rd = 0, io_wr = 0, swap = 0, enh = 0, go = 0;
    logic [9:0] io_addr = 10'h000;
    logic [7:0] io_wdata = 8'h00, cfg = 8'hB4, rdata, oe;
    logic [1:0] boot = 2'h1;
    fdcr_mode_e mode = FDCR_MODE_LEGACY;
    logic drq = 1, irq = 1, dack_n = 0, tc = 1;
    logic wg, rdi, wdo, d0_n, d1_n, m0_n, m1_n, crst_n, drq_o, drq_oe, irq_o, irq_oe;
    logic dackg_n, tc_g;
    int err_count = 0, samples_checked = 0;

    fdcr_regs uut (.CLK(clk), .RESET_N(rst_n), .IO_ADDR(io_addr), .IO_RD(io_rd),
        .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(rdata), .IO_RDATA_OE(oe),
        .STATUS_MODE(mode), .SWAP_DECODE(swap), .ENH_FLOPPY_MODE2(enh),
        .BOOT_DRIVE(boot), .DRIVE_TYPE_CONFIG_BYTE(cfg), .WRITE_GATE_OUT(wg),
        .READ_DATA_IN(rdi), .WRITE_DATA_OUT(wdo), .DRIVE_SEL_OUT_0_N(d0_n),
        .DRIVE_SEL_OUT_1_N(d1_n), .MOTOR_ON_OUT_0_N(m0_n), .MOTOR_ON_OUT_1_N(m1_n),
        .CTRL_RESET_N(crst_n), .CORE_DRQ(drq), .CORE_IRQ(irq), .DACK_N_IN(dack_n),
        .TC_IN(tc), .DRQ_OUT(drq_o), .DRQ_OE(drq_oe), .FLOPPY_IRQ_OUT(irq_o),
        .FLOPPY_IRQ_OE(irq_oe), .DACK_N_GATED(dackg_n), .TC_GATED(tc_g));
    fdcr_disk_model disk (.clk(clk), .go(go), .wr_gate(wg), .rdata(rdi), .wdata(wdo));

    initial forever #2 clk = ~clk;

    // ****
    // Shared tasks
    // ****
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task pins(input logic [3:0] e);
        chk({4'h0, d1_n, d0_n, m1_n, m0_n}, {4'h0, e});
    endtask
    task bus_wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        @(negedge clk);
        io_wr = 0;
    endtask
    // Answer stands one cycle, so it is sampled right after the strobe edge
    task bus_rd(input logic [9:0] a, input logic [7:0] ed, input logic [7:0] eo);
        @(negedge clk);
        io_addr = a;
        io_rd = 1;
        @(negedge clk);
        io_rd = 0;
        chk(oe, eo);
        chk(rdata & eo, ed);
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****
    // Scenarios
    // ****
    task t_decode;
        bus_rd(FDCR_ADDR_OCTL, 8'h00, 8'hFF);
        chk({7'h0, crst_n}, 8'h00);
        bus_wr(FDCR_ADDR_OCTL, 8'h1C);
        pins(4'hA);
        bus_rd(FDCR_ADDR_OCTL, 8'h1C, 8'hFF);
        bus_wr(FDCR_ADDR_OCTL, 8'h2D);
        pins(4'h5);
        bus_wr(FDCR_ADDR_OCTL, 8'hFE);
        pins(4'hC);
        bus_rd(FDCR_ADDR_OCTL, 8'h3E, 8'hFF);
        bus_wr(FDCR_ADDR_OCTL, 8'h1D);
        pins(4'hE);
        swap = 1;
        bus_wr(FDCR_ADDR_OCTL, 8'h1C);
        pins(4'h5);
        bus_wr(FDCR_ADDR_OCTL, 8'h2D);
        pins(4'hA);
        swap = 0;
        $display("decode test done");
    endtask
    task t_soft;
        int n;
        bus_wr(FDCR_ADDR_TAPE, 8'hFE);
        bus_wr(FDCR_ADDR_OCTL, 8'h1C);
        repeat (40) @(negedge clk);
        chk({7'h0, crst_n}, 8'h01);
        @(negedge clk);
        io_addr = FDCR_ADDR_OCTL;
        io_wdata = 8'h18;
        io_wr = 1;
        @(negedge clk);
        io_wdata = 8'h1C;
        @(negedge clk);
        io_wr = 0;
        chk({7'h0, crst_n}, 8'h00);
        n = 0;
        while (crst_n !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        // Low since the zero write, one cycle before the count started
        chk({7'h0, n >= FDCR_SOFT_RST_CYC - 1 && n < 60}, 8'h01);
        bus_wr(FDCR_ADDR_OCTL, 8'h18);
        chk({7'h0, crst_n}, 8'h00);
        bus_rd(FDCR_ADDR_OCTL, 8'h18, 8'hFF);
        pins(4'hA);
        bus_rd(FDCR_ADDR_TAPE, 8'h02, 8'h03);
        $display("soft reset test done");
    endtask
    task t_tape;
        enh = 1;
        for (int s = 0; s < 4; s++)
        begin
            boot = 2'(3 - s);
            bus_wr(FDCR_ADDR_OCTL, 8'h0C | 8'(s));
            bus_rd(FDCR_ADDR_TAPE, {2'h0, cfg[2*s+:2], boot, 2'h2}, 8'hFF);
        end
        enh = 0;
        $display("tape test done");
    endtask
    task t_status;
        mode = FDCR_MODE_ALT;
        bus_wr(FDCR_ADDR_OCTL, 8'h1C);
        bus_rd(FDCR_ADDR_DIR, 8'h00, 8'h00);
        bus_rd(FDCR_ADDR_STATUS_B, 8'hC3, 8'hFF);
        @(negedge clk);
        go = 1;
        @(negedge clk);
        go = 0;
        repeat (50) @(negedge clk);
        bus_rd(FDCR_ADDR_STATUS_B, 8'hDF, 8'hFF);
        bus_rd(FDCR_ADDR_DIR, 8'h00, 8'h00);
        bus_rd(FDCR_ADDR_STATUS_B, 8'hC3, 8'hFF);
        mode = FDCR_MODE_LEGACY;
        bus_rd(FDCR_ADDR_STATUS_B, 8'h00, 8'h00);
        bus_rd(10'h3F6, 8'h00, 8'h00);
        $display("status test done");
    endtask
    task t_gate;
        bus_wr(FDCR_ADDR_OCTL, 8'h14);
        @(negedge clk);
        chk({4'h0, drq_oe, irq_oe, dackg_n, tc_g}, 8'h02);
        bus_wr(FDCR_ADDR_OCTL, 8'h1C);
        @(negedge clk);
        chk({2'h0, drq_oe, irq_oe, drq_o, irq_o, dackg_n, tc_g}, 8'h3D);
        mode = FDCR_MODE_EXT;
        bus_wr(FDCR_ADDR_OCTL, 8'h14);
        @(negedge clk);
        chk({6'h0, drq_oe, irq_oe}, 8'h03);
        rst_n = 0;
        repeat (3) @(negedge clk);
        chk({6'h0, drq_oe, irq_oe}, 8'h03);
        rst_n = 1;
        bus_rd(FDCR_ADDR_OCTL, 8'h00, 8'hFF);
        mode = FDCR_MODE_LEGACY;
        $display("gating test done");
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        t_decode;
        t_soft;
        t_tape;
        t_status;
        t_gate;
        results;
    end
    // Whole run is about two hundred cycles; allow some twenty-five times that
    initial
    begin
        #20000;
        err_count++;
        results;
    end
endmodule

/* File: verilog/fdcr_pkg.sv */
// Constants and types shared by the floppy drive control register block
package fdcr_pkg;

    // ******************************************************
    // Register addresses on the host I/O bus
    // ******************************************************
    localparam logic [9:0] FDCR_ADDR_STATUS_B = 10'h3F1;
    localparam logic [9:0] FDCR_ADDR_OCTL = 10'h3F2;
    localparam logic [9:0] FDCR_ADDR_TAPE = 10'h3F3;
    localparam logic [9:0] FDCR_ADDR_DIR = 10'h3F7;

    // ******************************************************
    // Field positions of drive_output_control
    // ******************************************************
    localparam int FDCR_OCTL_SEL_LSB = 0;
    localparam int FDCR_OCTL_RST_BIT = 2;
    localparam int FDCR_OCTL_DMA_BIT = 3;
    localparam int FDCR_OCTL_MOT0_BIT = 4;
    localparam int FDCR_OCTL_MOT1_BIT = 5;

    // ******************************************************
    // Field positions of latched_drive_status_b
    // ******************************************************
    localparam int FDCR_LSTAT_WG_BIT = 2;
    localparam int FDCR_LSTAT_RD_BIT = 3;
    localparam int FDCR_LSTAT_WD_BIT = 4;
    localparam int FDCR_LSTAT_DS0_BIT = 5;
    localparam int FDCR_LSTAT_DS1_BIT = 6;

    // ******************************************************
    // Reset values and fixed read values
    // ******************************************************
    localparam logic [5:0] FDCR_OCTL_RESET = 6'h00;
    localparam logic [1:0] FDCR_TAPE_RESET = 2'h0;
    localparam logic [7:0] FDCR_LSTAT_ONES = 8'h83;
    localparam logic [7:0] FDCR_TAPE_OE_NORMAL = 8'h03;
    localparam logic [7:0] FDCR_OE_ALL = 8'hFF;

    // ******************************************************
    // Timing: least width of the controller reset
    // ******************************************************
    localparam int FDCR_CLK_PERIOD_NS = 4;
    localparam int FDCR_SOFT_RST_MIN_NS = 100;
    localparam int FDCR_SOFT_RST_CYC =
        (FDCR_SOFT_RST_MIN_NS + FDCR_CLK_PERIOD_NS - 1) / FDCR_CLK_PERIOD_NS;
    localparam logic [4:0] FDCR_SOFT_RST_LOAD = 5'(FDCR_SOFT_RST_CYC);

    // ******************************************************
    // Status behaviour modes
    // ******************************************************
    typedef enum logic [1:0]
    {
        FDCR_MODE_LEGACY = 2'b00,
        FDCR_MODE_ALT = 2'b01,
        FDCR_MODE_EXT = 2'b10
    } fdcr_mode_e;

endpackage

/* File: verilog/fdcr_regs.sv */
// Floppy drive control registers: drive output, tape assignment, latched status
//
// Function
// R01: Status bits 0, 1, 7 read one
// R02: Bit 2 latches write gate rise
// R03: Bit 3 latches read data fall
// R04: Bit 4 latches write data fall
// R05: Bits 5, 6 show select outputs
// R06: Output register writable; soft reset keeps it
// R07: Bits 1:0 encode one selected drive
// R08: Bit 2 low holds controller in reset
// R09: Reset pulse lasts at least 100 ns
// R10: Bit 3 gates DMA and interrupt pins
// R11: Extended mode keeps pins always enabled
// R12: Bits 4, 5 drive motor outputs
// R13: Bits 6, 7 always read zero
// R14: Normal decode of selects and motors
// R15: Swapped decode of selects and motors
// R16: Software writes 1CH or 2DH
// R17: Tape register bits 1:0 assign drive
// R18: Normal mode tape read drives 1:0
// R19: Tape register survives soft reset
// R20: Enhanced mode tape read layout
// R21: Drive type from config byte pair
// R22: Inputs pick decode and status mode
`timescale 1ns/100ps
module fdcr_regs
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Host I/O bus
    input wire logic [9:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic [7:0] IO_RDATA_OE,
    // Static configuration
    input wire fdcr_pkg::fdcr_mode_e STATUS_MODE,
    input wire logic SWAP_DECODE,
    input wire logic ENH_FLOPPY_MODE2,
    input wire logic [1:0] BOOT_DRIVE,
    input wire logic [7:0] DRIVE_TYPE_CONFIG_BYTE,
    // Disk interface levels watched by the status latch
    input wire logic WRITE_GATE_OUT,
    input wire logic READ_DATA_IN,
    input wire logic WRITE_DATA_OUT,
    // Drive outputs
    output logic DRIVE_SEL_OUT_0_N,
    output logic DRIVE_SEL_OUT_1_N,
    output logic MOTOR_ON_OUT_0_N,
    output logic MOTOR_ON_OUT_1_N,
    // Controller reset
    output logic CTRL_RESET_N,
    // DMA and interrupt pin gating
    input wire logic CORE_DRQ,
    input wire logic CORE_IRQ,
    input wire logic DACK_N_IN,
    input wire logic TC_IN,
    output logic DRQ_OUT,
    output logic DRQ_OE,
    output logic FLOPPY_IRQ_OUT,
    output logic FLOPPY_IRQ_OE,
    output logic DACK_N_GATED,
    output logic TC_GATED
);
    import fdcr_pkg::*;

    // ******************************************************
    // Helpers
    // ******************************************************

    // Pick one bit pair of a byte by a two-bit index
    function automatic logic [1:0] pick_pair(input logic [7:0] byte_in, input logic [1:0] idx);
        logic [1:0] res;
        res = 2'h0;
        case (idx)
            2'h0: res = byte_in[1:0];
            2'h1: res = byte_in[3:2];
            2'h2: res = byte_in[5:4];
            2'h3: res = byte_in[7:6];
            default: res = 2'h0;
        endcase
        return res;
    endfunction

    // Active-low select for one drive: code must match and its motor bit be set
    function automatic logic sel_low(input logic [1:0] code, input logic [1:0] want,
                                     input logic motor);
        return !((code == want) && motor);
    endfunction

    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed
    {
        logic [5:0] octl;
        logic [1:0] tape_sel;
        logic wg_latch;
        logic rd_latch;
        logic wd_latch;
        logic wg_prev;
        logic rd_prev;
        logic wd_prev;
        logic [4:0] rst_cnt;
        logic ctrl_rst_n;
        logic ds0_n;
        logic ds1_n;
        logic mtr0_n;
        logic mtr1_n;
        logic [7:0] rdata;
        logic [7:0] rdata_oe;
        logic drq;
        logic drq_oe;
        logic irq;
        logic irq_oe;
        logic dack_n;
        logic tc;
    } fdcr_state_s;

    fdcr_state_s st_q;
    fdcr_state_s st_d;

    logic [2:0] pins_sync;
    logic wg_now;
    logic rd_now;
    logic wd_now;

    // ******************************************************
    // Pin synchronisers
    // ******************************************************
    fdcr_sync #(.WIDTH(3)) u_sync
    (
        .clk(CLK),
        .reset_n(RESET_N),
        .async_in({WRITE_DATA_OUT, READ_DATA_IN, WRITE_GATE_OUT}),
        .sync_out(pins_sync)
    );

    assign wg_now = pins_sync[0];
    assign rd_now = pins_sync[1];
    assign wd_now = pins_sync[2];

    // ******************************************************
    // Next-state logic
    // ******************************************************
    always_comb
    begin
        logic wr_octl;
        logic wr_tape;
        logic rd_dir;
        logic [1:0] sel;
        logic mot0;
        logic mot1;
        logic dma_on;
        logic [7:0] lstat;
        logic [1:0] dtype;

        wr_octl = IO_WR && (IO_ADDR == FDCR_ADDR_OCTL);
        wr_tape = IO_WR && (IO_ADDR == FDCR_ADDR_TAPE);
        rd_dir = IO_RD && (IO_ADDR == FDCR_ADDR_DIR);
        sel = 2'h0;
        mot0 = 1'b0;
        mot1 = 1'b0;
        dma_on = 1'b0;
        lstat = 8'h00;
        dtype = 2'h0;
        st_d = st_q;

        // R06: writes accepted at any time
        if (wr_octl)
        begin
            st_d.octl = IO_WDATA[5:0];
        end
        // R17: tape drive number
        if (wr_tape)
        begin
            st_d.tape_sel = IO_WDATA[1:0];
        end

        sel = st_d.octl[FDCR_OCTL_SEL_LSB +: 2];
        mot0 = st_d.octl[FDCR_OCTL_MOT0_BIT];
        mot1 = st_d.octl[FDCR_OCTL_MOT1_BIT];

        // Edge history of the filtered levels
        st_d.wg_prev = wg_now;
        st_d.rd_prev = rd_now;
        st_d.wd_prev = wd_now;

        // Sticky latches: a new edge in the clearing cycle wins
        if (rd_dir)
        begin
            st_d.wg_latch = 1'b0;
            st_d.rd_latch = 1'b0;
            st_d.wd_latch = 1'b0;
        end
        // R02: write gate going active
        if (wg_now && !st_q.wg_prev)
        begin
            st_d.wg_latch = 1'b1;
        end
        // R03: read data going inactive
        if (!rd_now && st_q.rd_prev)
        begin
            st_d.rd_latch = 1'b1;
        end
        // R04: write data going inactive, not gated by write gate
        if (!wd_now && st_q.wd_prev)
        begin
            st_d.wd_latch = 1'b1;
        end

        // R08: reset held while the bit is zero
        // R09: stretch so even back-to-back writes give a full-width pulse
        if (!st_d.octl[FDCR_OCTL_RST_BIT])
        begin
            st_d.rst_cnt = FDCR_SOFT_RST_LOAD;
        end
        else if (st_q.rst_cnt != 5'h00)
        begin
            st_d.rst_cnt = st_q.rst_cnt - 5'h01;
        end
        st_d.ctrl_rst_n = st_d.octl[FDCR_OCTL_RST_BIT] && (st_d.rst_cnt == 5'h00);

        // R22: decode chosen by a static input
        if (SWAP_DECODE)
        begin
            // R15: swapped decode
            st_d.ds1_n = sel_low(sel, 2'h0, mot0);
            st_d.ds0_n = sel_low(sel, 2'h1, mot1);
            st_d.mtr1_n = !mot0;
            st_d.mtr0_n = !mot1;
        end
        else
        begin
            // R07: one drive at a time from the code
            // R14: normal decode
            st_d.ds0_n = sel_low(sel, 2'h0, mot0);
            st_d.ds1_n = sel_low(sel, 2'h1, mot1);
            // R12: motor bits drive the motor pins
            st_d.mtr0_n = !mot0;
            st_d.mtr1_n = !mot1;
        end

        // R11: extended mode keeps the pins enabled, even in reset
        // R10: otherwise the DMA bit gates them
        dma_on = (STATUS_MODE == FDCR_MODE_EXT) || st_d.octl[FDCR_OCTL_DMA_BIT];
        st_d.drq = CORE_DRQ;
        st_d.drq_oe = dma_on;
        st_d.irq = CORE_IRQ;
        st_d.irq_oe = dma_on;
        st_d.dack_n = dma_on ? DACK_N_IN : 1'b1;
        st_d.tc = dma_on ? TC_IN : 1'b0;

        // R01: unsupported selects and drive-present read one
        lstat = FDCR_LSTAT_ONES;
        lstat[FDCR_LSTAT_WG_BIT] = st_q.wg_latch;
        lstat[FDCR_LSTAT_RD_BIT] = st_q.rd_latch;
        lstat[FDCR_LSTAT_WD_BIT] = st_q.wd_latch;
        // R05: current select pins, active low
        lstat[FDCR_LSTAT_DS0_BIT] = st_q.ds0_n;
        lstat[FDCR_LSTAT_DS1_BIT] = st_q.ds1_n;

        // R21: drive type pair chosen by the select code
        dtype = pick_pair(DRIVE_TYPE_CONFIG_BYTE, st_q.octl[FDCR_OCTL_SEL_LSB +: 2]);

        // Read answer: one cycle after the strobe, bus floats otherwise
        st_d.rdata = 8'h00;
        st_d.rdata_oe = 8'h00;
        if (IO_RD)
        begin
            case (IO_ADDR)
                FDCR_ADDR_STATUS_B:
                begin
                    // Other modes leave this address floating
                    if (STATUS_MODE == FDCR_MODE_ALT)
                    begin
                        st_d.rdata = lstat;
                        st_d.rdata_oe = FDCR_OE_ALL;
                    end
                end
                FDCR_ADDR_OCTL:
                begin
                    // R13: unsupported motor enables read zero
                    st_d.rdata = {2'h0, st_q.octl};
                    st_d.rdata_oe = FDCR_OE_ALL;
                end
                FDCR_ADDR_TAPE:
                begin
                    if (ENH_FLOPPY_MODE2)
                    begin
                        // R20: enhanced layout with reserved top bits zero
                        st_d.rdata = {2'h0, dtype, BOOT_DRIVE, st_q.tape_sel};
                        st_d.rdata_oe = FDCR_OE_ALL;
                    end
                    else
                    begin
                        // R18: only the tape select bits are driven
                        st_d.rdata = {6'h00, st_q.tape_sel};
                        st_d.rdata_oe = FDCR_TAPE_OE_NORMAL;
                    end
                end
                default:
                begin
                    st_d.rdata = 8'h00;
                    st_d.rdata_oe = 8'h00;
                end
            endcase
        end
    end

    // ******************************************************
    // State register
    // ******************************************************
    // R19: only the hardware reset touches the tape and output registers
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            st_q <= '0;
            st_q.octl <= FDCR_OCTL_RESET;
            // R11: extended mode keeps the pins driven through reset
            st_q.drq_oe <= (STATUS_MODE == FDCR_MODE_EXT);
            st_q.irq_oe <= (STATUS_MODE == FDCR_MODE_EXT);
            st_q.tape_sel <= FDCR_TAPE_RESET;
            st_q.rst_cnt <= FDCR_SOFT_RST_LOAD;
            st_q.ds0_n <= 1'b1;
            st_q.ds1_n <= 1'b1;
            st_q.mtr0_n <= 1'b1;
            st_q.mtr1_n <= 1'b1;
            st_q.dack_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ******************************************************
    // Outputs, all straight from the state register
    // ******************************************************
    assign IO_RDATA = st_q.rdata;
    assign IO_RDATA_OE = st_q.rdata_oe;
    assign DRIVE_SEL_OUT_0_N = st_q.ds0_n;
    assign DRIVE_SEL_OUT_1_N = st_q.ds1_n;
    assign MOTOR_ON_OUT_0_N = st_q.mtr0_n;
    assign MOTOR_ON_OUT_1_N = st_q.mtr1_n;
    assign CTRL_RESET_N = st_q.ctrl_rst_n;
    assign DRQ_OUT = st_q.drq;
    assign DRQ_OE = st_q.drq_oe;
    assign FLOPPY_IRQ_OUT = st_q.irq;
    assign FLOPPY_IRQ_OE = st_q.irq_oe;
    assign DACK_N_GATED = st_q.dack_n;
    assign TC_GATED = st_q.tc;

endmodule

/* File: verilog/fdcr_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module fdcr_sync
#(
    parameter int WIDTH = 3
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed
    {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
    } fdcr_sync_s;

    fdcr_sync_s st_q;
    fdcr_sync_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Only the later stages are compared, never the first
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.stable[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

endmodule
